// >>> src/ssm_pkg.sv
// Constants and types shared by the stop mode selector
package ssm_pkg;

  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IST_OFS  = 8'h08;
  localparam logic [7:0] IMSK_OFS = 8'h0c;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int CTRL_W    = 5;
  localparam int CB_ALLOW  = 0;  // sleep_allow
  localparam int CB_LVEN   = 1;  // lowvolt_detect_enable
  localparam int CB_LVSLP  = 2;  // lowvolt_detect_in_sleep
  localparam int CB_PDSEL  = 3;  // partial_power_down_select
  localparam int CB_LVDRST = 4;  // Detector trip gives reset, not irq
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  localparam int IRQ_W   = 4;
  localparam int IB_STOP = 0;  // Stop mode entered
  localparam int IB_WAKE = 1;  // Woken by an interrupt
  localparam int IB_ILL  = 2;  // Illegal-opcode reset issued
  localparam int IB_LVD  = 3;  // Low-voltage warning
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  localparam int SB_ST   = 0;  // Two bits of state
  localparam int SB_REG  = 2;
  localparam int SB_DCLK = 3;
  localparam int SB_ADC  = 4;
  localparam int SB_CMP  = 5;

  // ******************************************************************
  // Wake sources
  // ******************************************************************
  localparam int WAKE_N = 6;
  localparam int WS_RTC = 0;
  localparam int WS_LVD = 1;
  localparam int WS_ACM = 2;
  localparam int WS_ADC = 3;
  localparam int WS_SCI = 4;
  localparam int WS_PIN = 5;

  typedef enum logic [1:0] {ST_RUN, ST_RET, ST_PDN} ssm_state_e;
  typedef enum logic [2:0] {
    MD_ILLEGAL, MD_RET_DBG, MD_RET_REG, MD_RET, MD_PDN
  } ssm_mode_e;

endpackage

// >>> src/ssm_mode_dec.sv
// Stop mode decoder from the control bits
`timescale 1ns/1ns
module ssm_mode_dec (
  input  wire logic           sleep_allow,
  input  wire logic           debug_mode_enable,
  input  wire logic           lowvolt_detect_enable,
  input  wire logic           lowvolt_detect_in_sleep,
  input  wire logic           partial_power_down_select,
  output ssm_pkg::ssm_mode_e  mode
);

  // Priority follows the selection table top to bottom
  always_comb begin
    if (!sleep_allow) begin
      mode = ssm_pkg::MD_ILLEGAL;
    end else if (debug_mode_enable) begin
      mode = ssm_pkg::MD_RET_DBG;
    end else if (lowvolt_detect_enable && lowvolt_detect_in_sleep) begin
      mode = ssm_pkg::MD_RET_REG;
    end else if (partial_power_down_select) begin
      mode = ssm_pkg::MD_PDN;
    end else begin
      mode = ssm_pkg::MD_RET;
    end
  end

endmodule

// >>> src/ssm_top.sv
// Stop mode selector with APB registers and wake handling
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module ssm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_exec,
  input  wire logic        reset_pin_n,
  input  wire logic [5:0]  wake_irq,
  input  wire logic        lvd_trip,
  input  wire logic        dbg_wr,
  input  wire logic        dbg_wdata,
  output logic             dbg_rdata,
  output logic             illegal_op_reset,
  output logic             full_reset_req,
  output logic             lvd_reset,
  output logic             wake_vec_valid,
  output logic      [2:0]  wake_vec_src,
  output logic             stop_clocks,
  output logic             state_hold,
  output logic             power_down,
  output logic             regulator_active,
  output logic             dbg_clk_keep,
  output logic             dbg_entry_allow,
  output logic             adc_stop_allow,
  output logic             cmp_bg_allow,
  output logic             irq
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  ssm_pkg::ssm_state_e             st_reg;
  ssm_pkg::ssm_mode_e              mode;
  logic [ssm_pkg::CTRL_W-1:0]      ctrl_reg;
  logic [ssm_pkg::IRQ_W-1:0]       ist_reg;
  logic [ssm_pkg::IRQ_W-1:0]       imsk_reg;
  logic [ssm_pkg::IRQ_W-1:0]       ist_set;
  logic                            dbg_en_reg;
  logic                            ent_lvd_reg;
  logic                            ent_lven_reg;
  logic                            ent_dbg_reg;
  logic                            wr_en;
  logic                            setup;
  logic                            hit;
  logic [31:0]                     rdata;
  logic                            stop_go;
  logic                            lvd_act;
  logic                            lvd_irq_ev;
  logic [ssm_pkg::WAKE_N-1:0]      wake_all;
  logic [2:0]                      wsrc;
  logic                            in_stop;

  // ******************************************************************
  // Mode decode
  // ******************************************************************
  ssm_mode_dec u_dec (
    .sleep_allow               (ctrl_reg[ssm_pkg::CB_ALLOW]),
    .debug_mode_enable         (dbg_en_reg),
    .lowvolt_detect_enable     (ctrl_reg[ssm_pkg::CB_LVEN]),
    .lowvolt_detect_in_sleep   (ctrl_reg[ssm_pkg::CB_LVSLP]),
    .partial_power_down_select (ctrl_reg[ssm_pkg::CB_PDSEL]),
    .mode                      (mode)
  );

  // Stop is only honoured in run; a stop pulse elsewhere is ignored
  assign stop_go = stop_exec && (st_reg == ssm_pkg::ST_RUN);
  assign in_stop = (st_reg != ssm_pkg::ST_RUN);

  // Detector works in run when enabled, in stop only with in-sleep set
  assign lvd_act = ctrl_reg[ssm_pkg::CB_LVEN]
                   && (!in_stop || ent_lvd_reg);
  assign lvd_irq_ev = lvd_trip && lvd_act && !ctrl_reg[ssm_pkg::CB_LVDRST];
  assign wake_all = wake_irq | (6'(lvd_irq_ev) << ssm_pkg::WS_LVD);

  // Lowest numbered source wins when several wake together
  always_comb begin
    wsrc = 3'h0;
    for (int i = ssm_pkg::WAKE_N - 1; i >= 0; i--) begin
      if (wake_all[i]) begin
        wsrc = 3'(i);
      end
    end
  end

  // ******************************************************************
  // State sequencing
  // ******************************************************************
  // Reset pin has priority over interrupts on exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ssm_pkg::ST_RUN;
    end else begin
      unique case (st_reg)
        ssm_pkg::ST_RUN: begin
          if (stop_go) begin
            unique case (mode)
              ssm_pkg::MD_ILLEGAL: st_reg <= ssm_pkg::ST_RUN;
              ssm_pkg::MD_PDN:     st_reg <= ssm_pkg::ST_PDN;
              default:             st_reg <= ssm_pkg::ST_RET;
            endcase
          end
        end
        ssm_pkg::ST_RET, ssm_pkg::ST_PDN: begin
          if (!reset_pin_n || (|wake_all)) begin
            st_reg <= ssm_pkg::ST_RUN;
          end
        end
        default: st_reg <= ssm_pkg::ST_RUN;
      endcase
    end
  end

  // Entry snapshot; stays fixed for the whole stop period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_lvd_reg  <= 1'b0;
      ent_lven_reg <= 1'b0;
      ent_dbg_reg  <= 1'b0;
    end else if (stop_go) begin
      ent_lvd_reg  <= ctrl_reg[ssm_pkg::CB_LVEN] && ctrl_reg[ssm_pkg::CB_LVSLP];
      ent_lven_reg <= ctrl_reg[ssm_pkg::CB_LVEN];
      ent_dbg_reg  <= dbg_en_reg;
    end
  end

  // Exit and fault pulses, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_op_reset <= 1'b0;
      full_reset_req   <= 1'b0;
      wake_vec_valid   <= 1'b0;
      wake_vec_src     <= 3'h0;
      lvd_reset        <= 1'b0;
    end else begin
      illegal_op_reset <= stop_go && (mode == ssm_pkg::MD_ILLEGAL);
      // Power-down loses state, so any exit from it is a full reset
      full_reset_req   <= in_stop && (!reset_pin_n
                          || ((st_reg == ssm_pkg::ST_PDN) && (|wake_all)));
      wake_vec_valid   <= (st_reg == ssm_pkg::ST_RET) && reset_pin_n
                          && (|wake_all);
      wake_vec_src     <= wsrc;
      lvd_reset        <= lvd_trip && lvd_act
                          && ctrl_reg[ssm_pkg::CB_LVDRST];
    end
  end

  // ******************************************************************
  // Power and clock controls, one cycle behind the state
  // ******************************************************************
  // Registered for glitch-free control of analog and clock gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_clocks      <= 1'b0;
      state_hold       <= 1'b0;
      power_down       <= 1'b0;
      regulator_active <= 1'b1;
      dbg_clk_keep     <= 1'b1;
      adc_stop_allow   <= 1'b0;
      cmp_bg_allow     <= 1'b0;
    end else begin
      stop_clocks      <= in_stop;
      state_hold       <= (st_reg == ssm_pkg::ST_RET);
      power_down       <= (st_reg == ssm_pkg::ST_PDN);
      regulator_active <= !in_stop || ent_lvd_reg || ent_dbg_reg;
      dbg_clk_keep     <= !in_stop || ent_dbg_reg;
      adc_stop_allow   <= (st_reg == ssm_pkg::ST_RET) && ent_lven_reg;
      cmp_bg_allow     <= (st_reg == ssm_pkg::ST_RET) && ent_lven_reg;
    end
  end

  // ******************************************************************
  // Debug-only control bit
  // ******************************************************************
  // Written only from the debug command port, never from APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_en_reg      <= 1'b0;
      dbg_rdata       <= 1'b0;
      dbg_entry_allow <= 1'b0;
    end else begin
      if (dbg_wr) begin
        dbg_en_reg <= dbg_wdata;
      end
      dbg_rdata       <= dbg_en_reg;
      dbg_entry_allow <= dbg_en_reg && !in_stop;
    end
  end

  // ******************************************************************
  // APB slave
  // ******************************************************************
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign hit   = (paddr == ssm_pkg::CTRL_OFS) || (paddr == ssm_pkg::STAT_OFS)
                 || (paddr == ssm_pkg::IST_OFS) || (paddr == ssm_pkg::IMSK_OFS);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr)
      ssm_pkg::CTRL_OFS: rdata[ssm_pkg::CTRL_W-1:0] = ctrl_reg;
      ssm_pkg::STAT_OFS: begin
        rdata[ssm_pkg::SB_ST +: 2]  = st_reg;
        rdata[ssm_pkg::SB_REG]      = regulator_active;
        rdata[ssm_pkg::SB_DCLK]     = dbg_clk_keep;
        rdata[ssm_pkg::SB_ADC]      = adc_stop_allow;
        rdata[ssm_pkg::SB_CMP]      = cmp_bg_allow;
      end
      ssm_pkg::IST_OFS:  rdata[ssm_pkg::IRQ_W-1:0] = ist_reg;
      ssm_pkg::IMSK_OFS: rdata[ssm_pkg::IRQ_W-1:0] = imsk_reg;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ssm_pkg::CTRL_RST;
      imsk_reg <= ssm_pkg::IRQ_RST;
    end else if (wr_en) begin
      if (paddr == ssm_pkg::CTRL_OFS) begin
        ctrl_reg <= pwdata[ssm_pkg::CTRL_W-1:0];
      end
      if (paddr == ssm_pkg::IMSK_OFS) begin
        imsk_reg <= pwdata[ssm_pkg::IRQ_W-1:0];
      end
    end
  end

  // ******************************************************************
  // Interrupt status
  // ******************************************************************
  always_comb begin
    ist_set = '0;
    ist_set[ssm_pkg::IB_STOP] = stop_go && (mode != ssm_pkg::MD_ILLEGAL);
    ist_set[ssm_pkg::IB_WAKE] = (st_reg == ssm_pkg::ST_RET) && reset_pin_n
                                && (|wake_all);
    ist_set[ssm_pkg::IB_ILL]  = stop_go && (mode == ssm_pkg::MD_ILLEGAL);
    ist_set[ssm_pkg::IB_LVD]  = lvd_irq_ev;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= ssm_pkg::IRQ_RST;
    end else if (wr_en && (paddr == ssm_pkg::IST_OFS)) begin
      ist_reg <= (ist_reg & ~pwdata[ssm_pkg::IRQ_W-1:0]) | ist_set;
    end else begin
      ist_reg <= ist_reg | ist_set;
    end
  end

  // Level interrupt, registered from the next status value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((ist_reg | ist_set) & imsk_reg
               & ~((wr_en && (paddr == ssm_pkg::IST_OFS))
                   ? (pwdata[ssm_pkg::IRQ_W-1:0] & ~ist_set) : 4'h0));
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go;
    stop_go && ctrl_reg[ssm_pkg::CB_ALLOW];
  endsequence

  sequence s_ret_dbg;
    (st_reg == ssm_pkg::ST_RET) ##1 (dbg_clk_keep && regulator_active);
  endsequence

  a_illegal_reset: assert property (
    stop_go && !ctrl_reg[ssm_pkg::CB_ALLOW] |=> illegal_op_reset && st_reg == ssm_pkg::ST_RUN)
    else $error("stop with sleep disallowed did not reset");
  a_run_no_stop: assert property (
    st_reg == ssm_pkg::ST_RUN && !stop_exec |=> st_reg == ssm_pkg::ST_RUN)
    else $error("left run without a stop");
  a_dbg_retention: assert property (s_go ##0 dbg_en_reg |=> s_ret_dbg)
    else $error("debug retention entry wrong");
  a_reg_retention: assert property (
    s_go ##0 !dbg_en_reg ##0 ctrl_reg[ssm_pkg::CB_LVEN] ##0 ctrl_reg[ssm_pkg::CB_LVSLP]
    |=> st_reg == ssm_pkg::ST_RET ##1 regulator_active)
    else $error("regulator retention entry wrong");
  a_pdn_select: assert property (
    s_go ##0 mode == ssm_pkg::MD_PDN |=> st_reg == ssm_pkg::ST_PDN ##1 power_down)
    else $error("power-down entry wrong");
  a_ret_hold: assert property (
    st_reg == ssm_pkg::ST_RET |=> state_hold && stop_clocks)
    else $error("retention hold missing");
  a_pin_exit: assert property (
    st_reg == ssm_pkg::ST_RET && !reset_pin_n
    |=> full_reset_req && st_reg == ssm_pkg::ST_RUN && !wake_vec_valid)
    else $error("reset pin exit wrong");
  a_irq_exit: assert property (
    st_reg == ssm_pkg::ST_RET && reset_pin_n && wake_irq[0]
    |=> wake_vec_valid && wake_vec_src == 3'h0 && !full_reset_req)
    else $error("interrupt exit wrong");
  // A reset-mode trip must pulse the reset and must not also raise a warning
  a_lvd_reset: assert property (
    lvd_trip && lvd_act && ctrl_reg[ssm_pkg::CB_LVDRST]
    |=> lvd_reset && !(ist_reg[ssm_pkg::IB_LVD] && !$past(ist_reg[ssm_pkg::IB_LVD])))
    else $error("detector reset missing");
  a_adc_gate: assert property (adc_stop_allow |-> $past(ent_lven_reg))
    else $error("adc allowed without detector");
  a_cmp_gate: assert property (
    cmp_bg_allow |-> $past(ent_lven_reg) && $past(st_reg) == ssm_pkg::ST_RET)
    else $error("comparator reference allowed without detector");
  a_dbg_clk_stop: assert property (
    in_stop && ent_dbg_reg |=> dbg_clk_keep)
    else $error("debug clocks stopped with debug enabled");
  a_reg_keep: assert property (
    in_stop && (ent_dbg_reg || ent_lvd_reg) |=> regulator_active)
    else $error("regulator left full regulation in stop");
  a_dbg_stable: assert property (!dbg_wr |=> $stable(dbg_en_reg))
    else $error("debug enable changed without command");

endmodule

// >>> verification/ssm_core_model.sv
// Behavioural model of the processor core and the debug command port
`timescale 1ns/1ns
module ssm_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stop_cmd,
  input  wire logic [1:0] delay,
  input  wire logic       dbg_cmd,
  input  wire logic       dbg_val,
  output logic            stop_exec,
  output logic            dbg_wr,
  output logic            dbg_wdata
);
  logic       pend_reg;
  logic [1:0] cnt_reg;

  // Stop comes a few instructions late, so entry is prompt or slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg  <= 1'b0;
      cnt_reg   <= 2'h0;
      stop_exec <= 1'b0;
    end else begin
      stop_exec <= 1'b0;
      if (stop_cmd) begin
        pend_reg <= 1'b1;
        cnt_reg  <= delay;
      end else if (pend_reg && cnt_reg == 2'h0) begin
        stop_exec <= 1'b1;  // One pulse per stop instruction
        pend_reg  <= 1'b0;
      end else if (pend_reg) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

  // Debug enable changes by debugger command only; data is not held after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_wr    <= 1'b0;
      dbg_wdata <= 1'b0;
    end else begin
      dbg_wr    <= dbg_cmd;
      dbg_wdata <= dbg_cmd ? dbg_val : ~dbg_wdata;
    end
  end
endmodule

// >>> verification/stop_mode_selector_tb_top.sv
// Self-checking testbench for the stop mode selector
`timescale 1ns/1ns
module stop_mode_selector_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_pin_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  wake_irq;
  logic [2:0]  wake_vec_src, src_seen;
  logic [1:0]  delay, st;
  logic [4:0]  cfg;
  logic [3:0]  mask;
  logic        stop_exec, lvd_trip, dbg_wr, dbg_wdata, dbg_rdata, err, dbg, xr;
  logic        illegal_op_reset, full_reset_req, lvd_reset, wake_vec_valid, stop_clocks;
  logic        state_hold, power_down, regulator_active, dbg_clk_keep, dbg_entry_allow;
  logic        adc_stop_allow, cmp_bg_allow, irq, stop_cmd, dbg_cmd, dbg_val;
  int          err_count = 0;
  int          comparisons = 0;
  int          n_ill = 0;
  int          n_rst = 0;
  int          n_wv = 0;
  int          n_lvd = 0;
  int          n, a, b, w, src;

  ssm_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_exec(stop_exec), .reset_pin_n(reset_pin_n), .wake_irq(wake_irq),
    .lvd_trip(lvd_trip), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
    .illegal_op_reset(illegal_op_reset), .full_reset_req(full_reset_req),
    .lvd_reset(lvd_reset), .wake_vec_valid(wake_vec_valid), .wake_vec_src(wake_vec_src),
    .stop_clocks(stop_clocks), .state_hold(state_hold), .power_down(power_down),
    .regulator_active(regulator_active), .dbg_clk_keep(dbg_clk_keep),
    .dbg_entry_allow(dbg_entry_allow), .adc_stop_allow(adc_stop_allow),
    .cmp_bg_allow(cmp_bg_allow), .irq(irq)
  );

  ssm_core_model i_core (
    .pclk(pclk), .presetn(presetn), .stop_cmd(stop_cmd), .delay(delay),
    .dbg_cmd(dbg_cmd), .dbg_val(dbg_val), .stop_exec(stop_exec),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata)
  );

  // 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Pulse counters; sampled values at each edge, so no race with the bench
  always @(posedge pclk) begin
    if (illegal_op_reset === 1'b1) n_ill <= n_ill + 1;
    if (full_reset_req === 1'b1) n_rst <= n_rst + 1;
    if (lvd_reset === 1'b1) n_lvd <= n_lvd + 1;
    if (wake_vec_valid === 1'b1) begin
      n_wv     <= n_wv + 1;
      src_seen <= wake_vec_src;
    end
  end

  // ******************************************************************
  // Shared tasks and expectations
  // ******************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected state code: 0 run (stop refused), 1 retention, 2 power-down
  function automatic logic [1:0] exp_state(input logic [4:0] c, input logic d);
    if (c[ssm_pkg::CB_ALLOW] !== 1'b1) return 2'h0;
    if (d || (c[ssm_pkg::CB_LVEN] && c[ssm_pkg::CB_LVSLP])) return 2'h1;
    return c[ssm_pkg::CB_PDSEL] ? 2'h2 : 2'h1;
  endfunction

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, stop_cmd, dbg_cmd, dbg_val} = '0;
    {wake_irq, lvd_trip, delay} = '0;
    reset_pin_n = 1'b1;
    presetn = 1'b0;
    void'($urandom(32'h5d879d50));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reg_act_rst", regulator_active, 1);
    apb(0, ssm_pkg::CTRL_OFS, 0);
    chk("ctrl_rst", rd, 32'h0);
    apb(0, ssm_pkg::IMSK_OFS, 0);
    chk("mask_rst", rd, 32'h0);
    apb(1, 8'h10, 32'hffffffff);
    chk("unmap_wr_err", err, 1);
    apb(0, 8'h10, 0);
    chk("unmap_rd_err", err, 1);
    chk("unmap_rd_data", rd, 32'h0);
    apb(1, ssm_pkg::CTRL_OFS, 32'hffffffff);
    chk("dbg_bus_write", dbg_rdata, 0);
    chk("no_stop_yet", state_hold | power_down, 0);
    apb(0, ssm_pkg::CTRL_OFS, 0);
    chk("ctrl_bits", rd, 32'h1f);
    // Detector trip as reset, then as a warning interrupt
    for (int m = 0; m < 2; m++) begin
      apb(1, ssm_pkg::CTRL_OFS, (m == 0) ? 32'h12 : 32'h02);
      a = n_lvd;
      lvd_trip <= 1'b1;
      @(posedge pclk);
      lvd_trip <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("lvd_reset", n_lvd != a, m == 0);
      apb(0, ssm_pkg::IST_OFS, 0);
      chk("lvd_warn", rd[ssm_pkg::IB_LVD], m == 1);
      apb(1, ssm_pkg::IST_OFS, 32'hf);
    end
    // All combinations of the four low control bits with debug off and on first, then random ones
    for (int i = 0; i < 48; i++) begin
      cfg = (i < 32) ? i[4:0] : 5'($urandom);
      dbg = cfg[4];
      mask = 4'($urandom);
      apb(1, ssm_pkg::IMSK_OFS, {28'h0, mask});
      dbg_val <= dbg;
      dbg_cmd <= 1'b1;
      @(posedge pclk);
      dbg_cmd <= 1'b0;
      // Write lands one edge after the strobe, the copies one edge later still
      repeat (3) @(posedge pclk);
      chk("dbg_rdata", dbg_rdata, dbg);
      chk("dbg_entry", dbg_entry_allow, dbg);
      apb(1, ssm_pkg::CTRL_OFS, {28'h0, cfg[3:0]});
      apb(0, ssm_pkg::STAT_OFS, 0);
      chk("run_before_stop", rd[1:0], 0);
      st = exp_state({1'b0, cfg[3:0]}, dbg);
      delay <= 2'($urandom);
      stop_cmd <= 1'b1;
      @(posedge pclk);
      stop_cmd <= 1'b0;
      a = n_ill;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (stop_exec !== 1'b1 && n < 10);
      if (n >= 10) begin
        err_count++;
        test_done();
      end
      repeat (3) @(posedge pclk);
      chk("illegal_pulses", n_ill - a, st == 0);
      apb(0, ssm_pkg::STAT_OFS, 0);
      chk("state", rd[1:0], st);
      apb(0, ssm_pkg::IST_OFS, 0);
      chk("ist_entry", rd, (st == 0) ? 32'h4 : 32'h1);
      chk("irq", irq, |(rd[3:0] & mask));
      if (st != 0) begin
        chk("hold", state_hold, st == 1);
        chk("clk_stop", stop_clocks, 1);
        chk("pdn", power_down, st == 2);
        chk("regulator", regulator_active, dbg | (cfg[1] & cfg[2]));
        chk("dbg_clk", dbg_clk_keep, dbg);
        chk("dbg_entry_stop", dbg_entry_allow, 0);
        chk("adc", adc_stop_allow, st == 1 && cfg[1]);
        chk("cmp", cmp_bg_allow, st == 1 && cfg[1]);
        apb(0, ssm_pkg::CTRL_OFS, 0);
        chk("ctrl_kept", rd, {28'h0, cfg[3:0]});
        src = $urandom_range(0, 6);
        if (src == 6) reset_pin_n <= 1'b0;
        else wake_irq[src] <= 1'b1;
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        wake_irq <= 6'h00;
        b = n_rst;
        w = n_wv;
        repeat (3) @(posedge pclk);
        xr = (src == 6) || (st == 2);
        chk("full_reset", n_rst - b, xr);
        chk("wake_vec", n_wv - w, !xr);
        if (!xr) chk("wake_src", src_seen, src);
        chk("hold_exit", state_hold | power_down, 0);
        chk("clk_exit", stop_clocks, 0);
      end
      apb(1, ssm_pkg::IST_OFS, 32'hf);
      apb(0, ssm_pkg::IST_OFS, 0);
      chk("ist_clear", rd, 32'h0);
      chk("irq_clear", irq, 0);
    end
    test_done();
  end

  // Hang guard
  initial begin
    #900000;
    err_count++;
    test_done();
  end
endmodule
